// ### common/cc_attach_pkg.sv
// Constants shared by the attach detector and its debouncer.
// Assumes one 25 MHz system clock and comparator outputs from analog pins.
package cc_attach_pkg;
    // System clock and time bases
    localparam int CLK_MHZ = 25;
    localparam int KEEPALIVE_PERIOD_NS = 50000;
    localparam int SAMPLE_CYCLES = KEEPALIVE_PERIOD_NS * CLK_MHZ / 1000;
    localparam int DEB_UNIT_US = 1600;
    localparam int DEB_UNIT_CYCLES = DEB_UNIT_US * CLK_MHZ;
    localparam int HS_OSC_MHZ = 48;
    // Field widths
    localparam int THR_W = 5;
    localparam int DEB_W = 8;
    localparam int LVL_W = 8;
    // Comparator control codes
    localparam logic [1:0] CMP_OFF = 2'h0;
    localparam logic [1:0] CMP_CC1 = 2'h1;
    localparam logic [1:0] CMP_CC2 = 2'h2;
    localparam logic [1:0] CMP_BOTH = 2'h3;
    // Pull-up advertisement codes
    localparam logic [1:0] RP_OFF = 2'h0;
    localparam logic [1:0] RP_DEFAULT = 2'h1;
    localparam logic [1:0] RP_1A5 = 2'h2;
    localparam logic [1:0] RP_3A0 = 2'h3;
    // Pull-down codes
    localparam logic [1:0] PD_NONE = 2'h0;
    localparam logic [1:0] PD_RD_TRIM = 2'h1;
    localparam logic [1:0] PD_RD_DB = 2'h2;
    localparam logic [1:0] PD_RA = 2'h3;
    // Flag positions in the flag vector
    localparam int FLG_CC_VALID = 0;
    localparam int FLG_CC1_CHG = 1;
    localparam int FLG_CC2_CHG = 2;
    localparam int FLG_VBUS_VALID = 3;
    localparam int FLG_VBUS_CHG = 4;
    localparam int FLG_W = 5;
    // Summary positions in the top enable
    localparam int SUM_CC = 0;
    localparam int SUM_PWR = 1;
    localparam int SUM_VBUS = 2;
    // Reset values
    localparam logic [1:0] CMP_RST = CMP_OFF;
    localparam logic [1:0] PD_RST = PD_RD_DB;
    localparam logic [1:0] RP_RST = RP_OFF;
    // Oscillator state
    typedef enum logic [1:0] {OSC_OFF = 2'b01, OSC_ON = 2'b10} osc_state_e;
endpackage : cc_attach_pkg

// ### rtl/thr_debouncer.sv
// Per-threshold debouncer for one comparator channel.
// Assumes samples arrive on sample_stb and unit_tick paces the debounce time.
`timescale 1ns/100ps
module thr_debouncer
    import cc_attach_pkg::*;
#(
    parameter int W = THR_W
)
(
    // Clocking
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Control
    input wire logic enable,
    input wire logic sample_stb,
    input wire logic unit_tick,
    input wire logic [DEB_W-1:0] deb_time,
    input wire logic [W-1:0] deb_mask,
    input wire logic [W-1:0] sample,
    // Results
    output logic [W-1:0] stable,
    output logic [W-1:0] changed,
    output logic first_done,
    output logic busy
);
    logic [W-1:0] stable_reg, stable_next, changed_next;
    logic [DEB_W-1:0] cnt_reg, cnt_next;
    logic first_reg, first_next, busy_reg, busy_next;
    logic [W-1:0] diff;

    // Only thresholds marked for debouncing may move the stable value
    always_comb
    begin
        diff = (sample ^ stable_reg) & deb_mask;
        stable_next = stable_reg;
        changed_next = '0;
        cnt_next = cnt_reg;
        first_next = first_reg;
        busy_next = busy_reg;
        if (!enable)
        begin
            cnt_next = '0;
            first_next = 1'b0;
            // Busy falls at the next sample slot, so the idle status is honest
            if (sample_stb)
                busy_next = 1'b0;
        end
        else if (sample_stb)
        begin
            busy_next = 1'b1;
            if (diff == '0)
            begin
                cnt_next = '0;
                first_next = 1'b1;
            end
            else if (cnt_reg >= deb_time)
            begin
                stable_next = stable_reg ^ diff;
                changed_next = diff;
                cnt_next = '0;
                first_next = 1'b1;
            end
        end
        else if (unit_tick && diff != '0 && cnt_reg != '1)
            cnt_next = cnt_reg + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stable_reg <= '0;
            changed <= '0;
            cnt_reg <= '0;
            first_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            stable_reg <= stable_next;
            changed <= changed_next;
            cnt_reg <= cnt_next;
            first_reg <= first_next;
            busy_reg <= busy_next;
        end
    end

    assign stable = stable_reg;
    assign first_done = first_reg;
    assign busy = busy_reg;
endmodule : thr_debouncer

// ### rtl/cc_vbus_attach_detect.sv
// Type-C attach and detach detector: CC and VBUS sampling, debounce, flags.
// Assumes synchronous host control bits on clk_sys and raw comparator pins.
`timescale 1ns/100ps
module cc_vbus_attach_detect
    import cc_attach_pkg::*;
#(
    parameter int UNIT_CYCLES = DEB_UNIT_CYCLES,
    parameter int N_THR = THR_W
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Serial control port activity and clock control
    input wire logic host_access,
    input wire logic keepalive_only,
    // CC line control
    input wire logic [1:0] cc_comp_ctrl,
    input wire logic cc_debounce_en,
    input wire logic [1:0] cc1_pull_down,
    input wire logic [1:0] cc2_pull_down,
    input wire logic [1:0] cc1_pull_up,
    input wire logic [1:0] cc2_pull_up,
    input wire logic [1:0] cc_comm_select,
    input wire logic [DEB_W-1:0] cc_match_debounce_time,
    input wire logic [N_THR-1:0] cc1_threshold_debounce_enable,
    input wire logic [N_THR-1:0] cc2_threshold_debounce_enable,
    input wire logic [N_THR-1:0] cc1_threshold_sample_enable,
    input wire logic [N_THR-1:0] cc2_threshold_sample_enable,
    input wire logic [N_THR-1:0] cc1_threshold_irq_enable,
    input wire logic [N_THR-1:0] cc2_threshold_irq_enable,
    // VBUS control
    input wire logic [1:0] vbus_comp_ctrl,
    input wire logic vbus_debounce_en,
    input wire logic [DEB_W-1:0] vbus_debounce_time,
    input wire logic [LVL_W-1:0] vbus_level_low,
    input wire logic [LVL_W-1:0] vbus_level_high,
    input wire logic [1:0] vbus_threshold_irq_enable,
    // Interrupt enables and clears
    input wire logic [2:0] cc_irq_enable,
    input wire logic power_irq_enable,
    input wire logic [2:0] top_irq_enable,
    input wire logic [FLG_W-1:0] flag_clear,
    // Analog comparator outputs
    input wire logic [N_THR-1:0] cc_comp_raw,
    input wire logic [1:0] vbus_presence_comparator,
    // Analog front-end controls
    output logic [1:0] cc1_pd_sel,
    output logic [1:0] cc2_pd_sel,
    output logic [1:0] cc1_rp_sel,
    output logic [1:0] cc2_rp_sel,
    output logic [1:0] bb_cc_sel,
    output logic cc_mux_pin2,
    output logic cc_comp_on,
    output logic vbus_comp_on,
    output logic [LVL_W-1:0] vbus_dac_low,
    output logic [LVL_W-1:0] vbus_dac_high,
    output logic hs_osc_enable,
    // Status
    output logic cc_debouncer_busy,
    output logic vbus_debouncer_busy,
    output logic [N_THR-1:0] cc1_pin_match_state,
    output logic [N_THR-1:0] cc2_pin_match_state,
    output logic [N_THR-1:0] cc1_pin_change_status,
    output logic [N_THR-1:0] cc2_pin_change_status,
    output logic [1:0] state_a,
    output logic [1:0] vbus_change_status,
    output logic [FLG_W-1:0] irq_flags,
    output logic cc_summary_irq,
    output logic power_summary_irq,
    output logic vbus_summary_irq,
    output logic irq_n
);
    localparam int UNIT_W = $clog2(UNIT_CYCLES + 1);
    localparam int SMP_W = $clog2(SAMPLE_CYCLES + 1);
    localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);
    localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(SAMPLE_CYCLES - 1);

    // Comparator pins come from the analog domain: two flops before use
    logic [N_THR-1:0] cc_meta_reg, cc_sync_reg;
    logic [1:0] vb_meta_reg, vb_sync_reg;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cc_meta_reg <= '0;
            cc_sync_reg <= '0;
            vb_meta_reg <= '0;
            vb_sync_reg <= '0;
        end
        else if (clk_en)
        begin
            cc_meta_reg <= cc_comp_raw;
            cc_sync_reg <= cc_meta_reg;
            vb_meta_reg <= vbus_presence_comparator;
            vb_sync_reg <= vb_meta_reg;
        end
    end

    // Time bases: keep-alive sample slot and debounce unit
    logic [SMP_W-1:0] smp_cnt_reg, smp_cnt_next;
    logic [UNIT_W-1:0] unit_cnt_reg, unit_cnt_next;
    logic smp_tick, unit_tick;
    always_comb
    begin
        smp_tick = (smp_cnt_reg == SMP_LAST);
        unit_tick = (unit_cnt_reg == UNIT_LAST);
        smp_cnt_next = smp_tick ? '0 : smp_cnt_reg + 1'b1;
        unit_cnt_next = unit_tick ? '0 : unit_cnt_reg + 1'b1;
    end

    // The slot counter ignores the fast oscillator state on purpose,
    // so sampling never stops in keep-alive mode
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            smp_cnt_reg <= '0;
            unit_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            smp_cnt_reg <= smp_cnt_next;
            unit_cnt_reg <= unit_cnt_next;
        end
    end

    // Fast oscillator control: wake on host access, sleep on request
    osc_state_e osc_reg, osc_next;
    always_comb
    begin
        osc_next = osc_reg;
        unique case (osc_reg)
            OSC_OFF: if (host_access) osc_next = OSC_ON;
            OSC_ON: if (keepalive_only && !host_access) osc_next = OSC_OFF;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            osc_reg <= OSC_OFF;
        else if (clk_en)
            osc_reg <= osc_next;
    end

    // CC pin steering: alternate pins each slot when both are chosen
    logic pin2_reg, pin2_next;
    logic cc_on, vb_on, stb1, stb2;
    always_comb
    begin
        cc_on = (cc_comp_ctrl != CMP_OFF) && cc_debounce_en;
        vb_on = (vbus_comp_ctrl != CMP_OFF) && vbus_debounce_en;
        pin2_next = pin2_reg;
        if (smp_tick)
        begin
            unique case (cc_comp_ctrl)
                CMP_CC1: pin2_next = 1'b0;
                CMP_CC2: pin2_next = 1'b1;
                CMP_BOTH: pin2_next = !pin2_reg;
                CMP_OFF: pin2_next = pin2_reg;
            endcase
        end
        // Stopped debouncers strobe every slot so busy drops
        stb1 = smp_tick && (!pin2_reg || !cc_on || cc_comp_ctrl == CMP_CC2);
        stb2 = smp_tick && (pin2_reg || !cc_on || cc_comp_ctrl == CMP_CC1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            pin2_reg <= 1'b0;
        else if (clk_en)
            pin2_reg <= pin2_next;
    end

    // Debouncers: sample enables mask what is seen, debounce enables
    // mask what may move
    logic [N_THR-1:0] st1, st2, ch1, ch2;
    logic [1:0] stv, chv;
    logic f1, f2, fv, b1, b2, bv;
    thr_debouncer #(.W(N_THR)) u_deb_cc1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(cc_on && cc_comp_ctrl != CMP_CC2),
        .sample_stb(stb1),
        .unit_tick(unit_tick && !pin2_reg),
        .deb_time(cc_match_debounce_time),
        .deb_mask(cc1_threshold_debounce_enable),
        .sample(cc_sync_reg & cc1_threshold_sample_enable),
        .stable(st1),
        .changed(ch1),
        .first_done(f1),
        .busy(b1)
    );
    thr_debouncer #(.W(N_THR)) u_deb_cc2 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(cc_on && cc_comp_ctrl != CMP_CC1),
        .sample_stb(stb2),
        .unit_tick(unit_tick && pin2_reg),
        .deb_time(cc_match_debounce_time),
        .deb_mask(cc2_threshold_debounce_enable),
        .sample(cc_sync_reg & cc2_threshold_sample_enable),
        .stable(st2),
        .changed(ch2),
        .first_done(f2),
        .busy(b2)
    );
    thr_debouncer #(.W(2)) u_deb_vbus (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(vb_on),
        .sample_stb(smp_tick),
        .unit_tick(unit_tick),
        .deb_time(vbus_debounce_time),
        .deb_mask(2'h3),
        .sample(vb_sync_reg),
        .stable(stv),
        .changed(chv),
        .first_done(fv),
        .busy(bv)
    );

    // Sticky flags and change status; a set in the clearing cycle wins
    logic [FLG_W-1:0] flag_reg, flag_next, flag_set;
    logic [N_THR-1:0] chg1_reg, chg1_next, chg2_reg, chg2_next;
    logic [1:0] chgv_reg, chgv_next;
    logic f1_d_reg, f2_d_reg, fv_d_reg;
    logic both_first;
    always_comb
    begin
        // Valid once every pin in use has its first result
        both_first = (f1 || cc_comp_ctrl == CMP_CC2) && (f2 || cc_comp_ctrl == CMP_CC1);
        flag_set = '0;
        flag_set[FLG_CC_VALID] = both_first && !(f1_d_reg && f2_d_reg) && cc_on;
        flag_set[FLG_CC1_CHG] = |(ch1 & cc1_threshold_irq_enable);
        flag_set[FLG_CC2_CHG] = |(ch2 & cc2_threshold_irq_enable);
        flag_set[FLG_VBUS_VALID] = fv && !fv_d_reg;
        flag_set[FLG_VBUS_CHG] = |(chv & vbus_threshold_irq_enable);
        flag_next = (flag_reg & ~flag_clear) | flag_set;
        chg1_next = flag_clear[FLG_CC1_CHG] ? ch1 : (chg1_reg | ch1);
        chg2_next = flag_clear[FLG_CC2_CHG] ? ch2 : (chg2_reg | ch2);
        chgv_next = flag_clear[FLG_VBUS_CHG] ? chv : (chgv_reg | chv);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            flag_reg <= '0;
            chg1_reg <= '0;
            chg2_reg <= '0;
            chgv_reg <= '0;
            f1_d_reg <= 1'b0;
            f2_d_reg <= 1'b0;
            fv_d_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            flag_reg <= flag_next;
            chg1_reg <= chg1_next;
            chg2_reg <= chg2_next;
            chgv_reg <= chgv_next;
            f1_d_reg <= both_first;
            f2_d_reg <= both_first;
            fv_d_reg <= fv;
        end
    end

    // Summaries and the interrupt pin, all registered
    logic sum_cc, sum_pwr, sum_vb;
    always_comb
    begin
        sum_cc = |(flag_reg[FLG_CC2_CHG:FLG_CC_VALID] & cc_irq_enable);
        sum_pwr = flag_reg[FLG_VBUS_VALID] && power_irq_enable;
        sum_vb = flag_reg[FLG_VBUS_CHG];
    end

    // Output register group: pull, comm select and DAC controls mirror host fields
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cc1_pd_sel <= PD_RST;
            cc2_pd_sel <= PD_RST;
            cc1_rp_sel <= RP_RST;
            cc2_rp_sel <= RP_RST;
            bb_cc_sel <= CMP_RST;
            cc_mux_pin2 <= 1'b0;
            cc_comp_on <= 1'b0;
            vbus_comp_on <= 1'b0;
            vbus_dac_low <= '0;
            vbus_dac_high <= '0;
            hs_osc_enable <= 1'b0;
            cc_debouncer_busy <= 1'b0;
            vbus_debouncer_busy <= 1'b0;
            cc1_pin_match_state <= '0;
            cc2_pin_match_state <= '0;
            cc1_pin_change_status <= '0;
            cc2_pin_change_status <= '0;
            state_a <= '0;
            vbus_change_status <= '0;
            irq_flags <= '0;
            cc_summary_irq <= 1'b0;
            power_summary_irq <= 1'b0;
            vbus_summary_irq <= 1'b0;
            irq_n <= 1'b1;
        end
        else if (clk_en)
        begin
            cc1_pd_sel <= cc1_pull_down;
            cc2_pd_sel <= cc2_pull_down;
            cc1_rp_sel <= cc1_pull_up;
            cc2_rp_sel <= cc2_pull_up;
            bb_cc_sel <= cc_comm_select;
            cc_mux_pin2 <= pin2_reg;
            cc_comp_on <= cc_comp_ctrl != CMP_OFF;
            vbus_comp_on <= vbus_comp_ctrl != CMP_OFF;
            vbus_dac_low <= vbus_level_low;
            vbus_dac_high <= vbus_level_high;
            hs_osc_enable <= osc_next == OSC_ON;
            cc_debouncer_busy <= b1 || b2;
            vbus_debouncer_busy <= bv;
            cc1_pin_match_state <= st1 & cc1_threshold_sample_enable;
            cc2_pin_match_state <= st2 & cc2_threshold_sample_enable;
            cc1_pin_change_status <= chg1_reg;
            cc2_pin_change_status <= chg2_reg;
            state_a <= stv;
            vbus_change_status <= chgv_reg;
            irq_flags <= flag_reg;
            cc_summary_irq <= sum_cc;
            power_summary_irq <= sum_pwr;
            vbus_summary_irq <= sum_vb;
            // Low while any enabled summary holds
            irq_n <= !((sum_cc && top_irq_enable[SUM_CC]) || (sum_pwr && top_irq_enable[SUM_PWR])
                || (sum_vb && top_irq_enable[SUM_VBUS]));
        end
    end
endmodule : cc_vbus_attach_detect

// ### sim/cc_attach_checker.sv
// Checker for the attach detector: mirrors, busy timing, flags, interrupt.
// Assumes one clock domain and clk_en held high by the bench.
`timescale 1ns/100ps
module cc_attach_checker
    import cc_attach_pkg::*;
#(
    parameter int N_THR = THR_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Inputs watched
    input wire logic host_access,
    input wire logic keepalive_only,
    input wire logic [1:0] cc_comp_ctrl,
    input wire logic cc_debounce_en,
    input wire logic [1:0] cc1_pull_up,
    input wire logic [N_THR-1:0] cc1_threshold_sample_enable,
    input wire logic [2:0] cc_irq_enable,
    input wire logic [2:0] top_irq_enable,
    input wire logic [FLG_W-1:0] flag_clear,
    // Outputs watched
    input wire logic [1:0] cc1_rp_sel,
    input wire logic cc_comp_on,
    input wire logic hs_osc_enable,
    input wire logic cc_debouncer_busy,
    input wire logic [N_THR-1:0] cc1_pin_match_state,
    input wire logic [N_THR-1:0] cc1_pin_change_status,
    input wire logic [1:0] vbus_change_status,
    input wire logic [FLG_W-1:0] irq_flags,
    input wire logic irq_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    int idle_reg, idle_next, wake_reg, wake_next;
    // Slot waits outgrow a delay range, so count them
    always_comb
    begin
        idle_next = (!sys_rst && !cc_comp_on && cc_debouncer_busy) ? idle_reg + 1 : 0;
        wake_next = (!sys_rst && cc_comp_on && cc_debounce_en && !cc_debouncer_busy) ? wake_reg + 1 : 0;
    end
    always_ff @(posedge clk_sys)
    begin
        idle_reg <= idle_next;
        wake_reg <= wake_next;
    end
    // Steady masks and enables for a few cycles
    sequence s_mask_steady;
        $stable(cc1_threshold_sample_enable) [*3];
    endsequence
    sequence s_all_masked;
        (top_irq_enable == 3'h0) [*3];
    endsequence
    sequence s_cc1_pending;
        (irq_flags[FLG_CC1_CHG] && cc_irq_enable[1] && top_irq_enable[SUM_CC]) [*3];
    endsequence
    AST_PULL_UP_MIRROR: assert property (!$past(sys_rst) |-> cc1_rp_sel == $past(cc1_pull_up))
        else $error("pull-up select does not follow its field");
    AST_CC_COMP_ON: assert property (!$past(sys_rst) |-> cc_comp_on == ($past(cc_comp_ctrl) != CMP_OFF))
        else $error("comparator enable does not follow its control");
    AST_CC_STOP_IDLE: assert property (idle_reg <= 1300)
        else $error("debouncer busy too long after stop");
    AST_CC_BUSY_START: assert property (wake_reg <= 1300)
        else $error("debouncer busy late after start");
    AST_WAKE_OSC: assert property (host_access && !keepalive_only |-> ##[1:4] hs_osc_enable)
        else $error("fast oscillator not woken");
    AST_FLAG_STICKY: assert property (flag_clear == '0 |-> ##2 (irq_flags & $past(irq_flags)) == $past(irq_flags))
        else $error("flag dropped without a clear");
    AST_SAMPLE_MASK: assert property (s_mask_steady |-> (cc1_pin_match_state & ~cc1_threshold_sample_enable) == '0)
        else $error("unsampled threshold reads set");
    AST_CC1_CHANGE_STATUS: assert property ($rose(irq_flags[FLG_CC1_CHG]) |-> cc1_pin_change_status != '0)
        else $error("change flag without change status");
    AST_VBUS_CHANGE_STATUS: assert property ($rose(irq_flags[FLG_VBUS_CHG]) |-> vbus_change_status != '0)
        else $error("vbus flag without change status");
    AST_IRQ_MASKED: assert property (s_all_masked |-> irq_n)
        else $error("interrupt low while all masked");
    AST_IRQ_HELD: assert property (s_cc1_pending |-> !irq_n)
        else $error("interrupt high with enabled flag set");
endmodule : cc_attach_checker

bind cc_vbus_attach_detect cc_attach_checker #(.N_THR(N_THR)) u_checker (.*);

// ### sim/cc_port_partner.sv
// Remote port partner: a source advertising on one CC pin and powering VBUS.
// Assumes the bench sets attach, orientation, advertisement and VBUS.
`timescale 1ns/100ps
module cc_port_partner
    import cc_attach_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Scenario controls
    input wire logic attached,
    input wire logic on_pin2,
    input wire logic [1:0] adv_code,
    input wire logic vbus_on,
    // Device side
    input wire logic cc_mux_pin2,
    input wire logic cc_comp_on,
    input wire logic vbus_comp_on,
    output logic [THR_W-1:0] cc_comp_raw,
    output logic [1:0] vbus_presence_comparator
);
    logic [THR_W-1:0] raw_reg = 5'h00;
    logic [THR_W-1:0] raw_next;
    logic [1:0] vbus_reg = 2'h0;
    logic [1:0] vbus_next;
    // An unpowered comparator gives no steady reading, so it toggles
    always_comb
    begin
        raw_next = ~raw_reg;
        vbus_next = ~vbus_reg;
        if (cc_comp_on)
            raw_next = (attached && on_pin2 == cc_mux_pin2) ? (5'h01 << adv_code) - 5'h01 : 5'h00;
        if (vbus_comp_on)
            vbus_next = vbus_on ? 2'h3 : 2'h0;
    end
    always_ff @(posedge clk_sys)
    begin
        raw_reg <= raw_next;
        vbus_reg <= vbus_next;
    end
    assign cc_comp_raw = raw_reg;
    assign vbus_presence_comparator = vbus_reg;
endmodule : cc_port_partner

// ### sim/tb_top.sv
// Bench for the attach detector: sink attach, masks, VBUS attach and detach.
// Assumes clk_en stays high and a short debounce unit.
`timescale 1ns/100ps
module tb_top
    import cc_attach_pkg::*;
;
    localparam int UNITS = 20;
    logic clk_sys = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, host_access = 1'h0, keepalive_only = 1'h0;
    logic cc_debounce_en = 1'h0, vbus_debounce_en = 1'h0, power_irq_enable = 1'h0;
    logic attached = 1'h0, vbus_on = 1'h0;
    logic [1:0] cc_comp_ctrl = 2'h0, cc1_pull_down = 2'h2, cc2_pull_down = 2'h2, cc1_pull_up = 2'h0;
    logic [1:0] cc2_pull_up = 2'h0, cc_comm_select = 2'h0, vbus_comp_ctrl = 2'h0, vbus_threshold_irq_enable = 2'h0;
    logic [DEB_W-1:0] cc_match_debounce_time = 8'h00, vbus_debounce_time = 8'h00;
    logic [LVL_W-1:0] vbus_level_low = 8'h00, vbus_level_high = 8'h00;
    logic [THR_W-1:0] cc1_threshold_debounce_enable = 5'h00, cc2_threshold_debounce_enable = 5'h00;
    logic [THR_W-1:0] cc1_threshold_sample_enable = 5'h00, cc2_threshold_sample_enable = 5'h00;
    logic [THR_W-1:0] cc1_threshold_irq_enable = 5'h00, cc2_threshold_irq_enable = 5'h00, cc_comp_raw;
    logic [2:0] cc_irq_enable = 3'h0, top_irq_enable = 3'h0;
    logic [FLG_W-1:0] flag_clear = 5'h00, irq_flags;
    logic [1:0] vbus_presence_comparator, cc1_pd_sel, cc2_pd_sel, cc1_rp_sel, cc2_rp_sel, bb_cc_sel;
    logic [1:0] state_a, vbus_change_status;
    logic [LVL_W-1:0] vbus_dac_low, vbus_dac_high;
    logic [THR_W-1:0] cc1_pin_match_state, cc2_pin_match_state, cc1_pin_change_status, cc2_pin_change_status;
    logic cc_mux_pin2, cc_comp_on, vbus_comp_on, hs_osc_enable, cc_debouncer_busy, vbus_debouncer_busy;
    logic cc_summary_irq, power_summary_irq, vbus_summary_irq, irq_n;
    logic [1:0] rp_codes [4] = '{RP_OFF, RP_DEFAULT, RP_1A5, RP_3A0};
    int bad_count = 0;
    int checks_done = 0;

    cc_vbus_attach_detect #(.UNIT_CYCLES(UNITS)) DUT (.*);

    cc_port_partner u_partner (.on_pin2(1'h0), .adv_code(RP_3A0), .*);

    // 25 MHz clock
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Bit 0..4 flags, 5 CC busy, 6 VBUS busy; bounded against a hang
    task automatic wait_for(input int sel, input logic lvl, input int limit);
        logic [6:0] v;
        v = {vbus_debouncer_busy, cc_debouncer_busy, irq_flags};
        for (int n = 0; n < limit && v[sel] !== lvl; n++)
        begin
            @(posedge clk_sys);
            v = {vbus_debouncer_busy, cc_debouncer_busy, irq_flags};
        end
        chk(8'(v[sel]), 8'(lvl));
    endtask : wait_for

    task automatic clear_flags();
        flag_clear <= 5'h1f;
        tick(1);
        flag_clear <= 5'h00;
        tick(3);
    endtask : clear_flags

    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // Watchdog well past the longest expected run
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        tick(5);
        sys_rst <= 1'h0;
        tick(2);
        chk(8'(irq_n), 8'h01);
        chk(8'(cc1_pd_sel), 8'(PD_RST));
        // Front-end fields, every pull-up code in turn
        for (int c = 0; c < 4; c++)
        begin
            cc1_pull_up <= rp_codes[c];
            cc2_pull_up <= rp_codes[c];
            cc2_pull_down <= c[1:0];
            cc_comm_select <= c[1:0];
            vbus_level_low <= 8'(c) + 8'h10;
            tick(3);
            chk(8'({cc1_rp_sel, cc2_rp_sel}), 8'({c[1:0], c[1:0]}));
            chk(8'(cc2_pd_sel), 8'(c));
            chk(8'(bb_cc_sel), 8'(c));
            chk(vbus_dac_low, 8'(c) + 8'h10);
        end
        cc1_pull_down <= PD_RD_TRIM;
        cc2_pull_down <= PD_RD_TRIM;
        host_access <= 1'h1;
        tick(1);
        host_access <= 1'h0;
        tick(4);
        chk(8'(hs_osc_enable), 8'h01);
        chk(8'(cc1_pd_sel), 8'(PD_RD_TRIM));
        // Sink attach on CC1; each mask removes one crossed threshold
        cc_match_debounce_time <= 8'h02;
        cc1_threshold_debounce_enable <= 5'h1d;
        cc2_threshold_debounce_enable <= 5'h1d;
        cc1_threshold_sample_enable <= 5'h1b;
        cc2_threshold_sample_enable <= 5'h1b;
        cc1_threshold_irq_enable <= 5'h1f;
        cc2_threshold_irq_enable <= 5'h1f;
        cc_irq_enable <= 3'h7;
        top_irq_enable <= 3'h7;
        keepalive_only <= 1'h1;
        cc_comp_ctrl <= CMP_BOTH;
        cc_debounce_en <= 1'h1;
        wait_for(5, 1'h1, 2000);
        chk(8'(hs_osc_enable), 8'h00);
        wait_for(FLG_CC_VALID, 1'h1, 6000);
        chk(8'(cc1_pin_match_state), 8'h00);
        attached <= 1'h1;
        wait_for(FLG_CC1_CHG, 1'h1, 6000);
        tick(3);
        chk(8'(cc1_pin_match_state), 8'h01);
        chk(8'(cc1_pin_change_status), 8'h01);
        chk(8'(cc2_pin_match_state | cc2_pin_change_status), 8'h00);
        chk(8'(irq_n), 8'h00);
        // Masks at source and top level
        cc_irq_enable <= 3'h0;
        tick(4);
        chk(8'(cc_summary_irq), 8'h00);
        cc_irq_enable <= 3'h7;
        top_irq_enable <= 3'h0;
        tick(4);
        chk(8'(irq_n), 8'h01);
        top_irq_enable <= 3'h7;
        clear_flags();
        chk(8'(irq_flags[FLG_CC1_CHG]), 8'h00);
        chk(8'(cc1_pin_change_status), 8'h00);
        cc_comp_ctrl <= CMP_OFF;
        cc_debounce_en <= 1'h0;
        wait_for(5, 1'h0, 2000);
        // VBUS attach then detach, still on the keep-alive time base
        vbus_debounce_time <= 8'h01;
        vbus_threshold_irq_enable <= 2'h3;
        power_irq_enable <= 1'h1;
        vbus_level_high <= 8'hc0;
        vbus_comp_ctrl <= 2'h1;
        vbus_debounce_en <= 1'h1;
        wait_for(FLG_VBUS_VALID, 1'h1, 6000);
        tick(3);
        chk(8'({power_summary_irq, vbus_comp_on}), 8'h03);
        chk(vbus_dac_high, 8'hc0);
        vbus_on <= 1'h1;
        wait_for(FLG_VBUS_CHG, 1'h1, 6000);
        tick(3);
        chk(8'(state_a), 8'h03);
        chk(8'(vbus_summary_irq), 8'h01);
        clear_flags();
        vbus_on <= 1'h0;
        wait_for(FLG_VBUS_CHG, 1'h1, 6000);
        tick(3);
        chk(8'(state_a), 8'h00);
        chk(8'(vbus_change_status), 8'h03);
        chk(8'(irq_n), 8'h00);
        vbus_comp_ctrl <= 2'h0;
        vbus_debounce_en <= 1'h0;
        wait_for(6, 1'h0, 2000);
        report_and_stop();
    end
endmodule : tb_top
